/* File: tws_consts.svh */
// Register offsets, field positions, reset values, status codes and timing constants
// Functional notes
// RULE1 - Match address against upper seven own-address bits
// RULE2 - Own-address low bit enables general call 0x00
// RULE3 - Software sets enable and ack, clears start/stop
// RULE4 - Read direction bit selects transmit operation
// RULE5 - Address plus direction received sets flag, status
// RULE6 - Lost arbitration then addressed reports 0xB0
// RULE7 - Status 0xA8: load byte, ack enable decides last
// RULE8 - Status 0xB0: load byte, ack enable sets expectation
// RULE9 - Status 0xB8: load next byte, continue or last
// RULE10 - Status 0xC0: NACK, go not addressed after clear
// RULE11 - Start request on 0xC0/0xC8 sends START when free
// RULE12 - Status 0xC8: last byte acknowledged anyway
// RULE13 - Ack enable cleared mid-transfer makes byte last
// RULE14 - After last byte ignore clocks, release data line
// RULE15 - Ack enable zero suppresses own address response
// RULE16 - Deep sleep address match acknowledges, raises wake-up
// RULE17 - Hold clock low after wake match until cleared
// RULE18 - Data register need not hold last bus byte
// RULE19 - Software masks prescaler bits from status
// RULE20 - Flag cleared only by writing one; clear proceeds
// RULE21 - Stretch clock while flag set in addressed transfer
`ifndef TWS_CONSTS_SVH
`define TWS_CONSTS_SVH
`define TWS_OFS_OWN_ADDR 32'h0000_0000
`define TWS_OFS_CTRL 32'h0000_0004
`define TWS_OFS_STATUS 32'h0000_0008
`define TWS_OFS_DATA 32'h0000_000C
`define TWS_OFS_SLEEP 32'h0000_0010
`define TWS_BIT_FLAG 7
`define TWS_BIT_ACK_EN 6
`define TWS_BIT_START 5
`define TWS_BIT_STOP 4
`define TWS_BIT_ENABLE 2
`define TWS_RST_OWN_ADDR 8'h00
`define TWS_RST_CTRL 8'h00
`define TWS_RST_DATA 8'hFF
`define TWS_ST_START_SENT 8'h08
`define TWS_ST_SLA_R_ACK 8'hA8
`define TWS_ST_ARB_SLA_R 8'hB0
`define TWS_ST_DATA_ACK 8'hB8
`define TWS_ST_DATA_NACK 8'hC0
`define TWS_ST_LAST_ACK 8'hC8
`define TWS_ST_NO_INFO 8'hF8
`define TWS_START_HOLD_NS 4000
`define TWS_CLK_MHZ 50
`define TWS_RESP_OKAY 2'b00
`define TWS_RESP_SLVERR 2'b10
`endif

/* File: tws_pkg.sv */
// Types shared by the two-wire slave transmitter
package tws_pkg;
  typedef enum logic [2:0] {
    TWS_IDLE, TWS_ADDR, TWS_ADDR_ACK, TWS_WAIT, TWS_TX, TWS_TX_ACK,
    TWS_IGNORE, TWS_START_GEN
  } tws_state_t;
  typedef enum logic [2:0] {
    TWS_SEL_OWN, TWS_SEL_CTRL, TWS_SEL_STATUS, TWS_SEL_DATA,
    TWS_SEL_SLEEP, TWS_SEL_NONE
  } tws_sel_t;
endpackage

/* File: tws_slave_tx.sv */
// Two-wire slave transmitter with AXI4-Lite register access
//
// Implementation choices: the address map and the AXI4-Lite slave port.
`include "tws_consts.svh"
module tws_slave_tx (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic arb_lost,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_n,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  output logic wake_up
);
  localparam int HOLD_CYC =
    (`TWS_START_HOLD_NS * `TWS_CLK_MHZ + 999) / 1000;

  function automatic tws_pkg::tws_sel_t reg_sel(input logic [31:0] a);
    case (a)
      `TWS_OFS_OWN_ADDR: reg_sel = tws_pkg::TWS_SEL_OWN;
      `TWS_OFS_CTRL: reg_sel = tws_pkg::TWS_SEL_CTRL;
      `TWS_OFS_STATUS: reg_sel = tws_pkg::TWS_SEL_STATUS;
      `TWS_OFS_DATA: reg_sel = tws_pkg::TWS_SEL_DATA;
      `TWS_OFS_SLEEP: reg_sel = tws_pkg::TWS_SEL_SLEEP;
      default: reg_sel = tws_pkg::TWS_SEL_NONE;
    endcase
  endfunction

  tws_pkg::tws_state_t state;
  logic [7:0] own_slave_address;
  logic [7:0] serial_data_reg;
  logic [7:0] serial_status_reg;
  logic [1:0] prescaler;
  logic interrupt_flag, acknowledge_enable, start_request, stop_request;
  logic interface_enable, sleep_mode;
  logic aw_full, w_full;
  logic [31:0] aw_q, w_q;
  logic strb0_q;
  logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
  logic bus_busy, arb_pend, ack_seen;
  logic [3:0] bit_cnt;
  logic [7:0] shreg;
  logic [7:0] hold_cnt;

  // Handshakes and bus events
  wire aw_hs = awvalid && awready;
  wire w_hs = wvalid && wready;
  wire ar_hs = arvalid && arready;
  wire wr_fire = aw_full && w_full && !bvalid;
  wire next_aw_full = wr_fire ? 1'b0 : (aw_hs ? 1'b1 : aw_full);
  wire next_w_full = wr_fire ? 1'b0 : (w_hs ? 1'b1 : w_full);
  wire next_rvalid = ar_hs ? 1'b1 : (rready ? 1'b0 : rvalid);
  wire tws_pkg::tws_sel_t wsel = reg_sel(aw_q);
  wire tws_pkg::tws_sel_t rsel = reg_sel(araddr);
  wire wr_lane0 = wr_fire && strb0_q;
  wire wr_ctrl = wr_lane0 && wsel == tws_pkg::TWS_SEL_CTRL;
  wire flag_clear = wr_ctrl && w_q[`TWS_BIT_FLAG];
  wire scl_rise = scl_s2 && !scl_d;
  wire scl_fall = !scl_s2 && scl_d;
  wire start_det = scl_s2 && scl_d && sda_d && !sda_s2;
  wire stop_det = scl_s2 && scl_d && !sda_d && sda_s2;

  // Address decision after the eighth bit
  wire addr_done = state == tws_pkg::TWS_ADDR && bit_cnt == 4'd8 &&
    scl_fall;
  wire own_hit = shreg[7:1] == own_slave_address[7:1] && |shreg[7:1];
  wire gc_hit = shreg[7:1] == 7'h00 && own_slave_address[0]; // see RULE2
  wire addr_match = (own_hit || gc_hit) && shreg[0] && acknowledge_enable;
  wire tx_code = serial_status_reg == `TWS_ST_SLA_R_ACK ||
    serial_status_reg == `TWS_ST_ARB_SLA_R ||
    serial_status_reg == `TWS_ST_DATA_ACK;
  wire ack_done = state == tws_pkg::TWS_TX_ACK && scl_fall;
  wire [7:0] ack_code = !ack_seen ? `TWS_ST_DATA_NACK :
    (acknowledge_enable ? `TWS_ST_DATA_ACK : `TWS_ST_LAST_ACK);
  wire start_done = state == tws_pkg::TWS_START_GEN &&
    hold_cnt == 8'(HOLD_CYC - 1);
  wire addr_set = state == tws_pkg::TWS_ADDR_ACK && scl_fall;
  wire flag_set = addr_set || ack_done || start_done;
  wire [7:0] next_code = addr_set ?
    (arb_pend ? `TWS_ST_ARB_SLA_R : `TWS_ST_SLA_R_ACK) :
    (ack_done ? ack_code : `TWS_ST_START_SENT);
  wire in_transfer = state == tws_pkg::TWS_ADDR ||
    state == tws_pkg::TWS_ADDR_ACK || state == tws_pkg::TWS_TX ||
    state == tws_pkg::TWS_TX_ACK || state == tws_pkg::TWS_IGNORE;
  wire bus_event = in_transfer && (start_det || stop_det);
  wire [7:0] ctrl_rd = {interrupt_flag, acknowledge_enable, start_request,
    stop_request, 1'b0, interface_enable, 2'b00};
  wire [7:0] rd_byte =
    rsel == tws_pkg::TWS_SEL_OWN ? own_slave_address :
    rsel == tws_pkg::TWS_SEL_CTRL ? ctrl_rd :
    rsel == tws_pkg::TWS_SEL_STATUS ?
      {serial_status_reg[7:3], 1'b0, prescaler} :
    rsel == tws_pkg::TWS_SEL_DATA ? serial_data_reg :
    {7'h00, sleep_mode};

  // Bus slave channels
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `TWS_RESP_OKAY;
    end else begin
      aw_full <= next_aw_full;
      w_full <= next_w_full;
      awready <= !next_aw_full;
      wready <= !next_w_full;
      if (wr_fire) begin
        bvalid <= 1'b1;
        bresp <= wsel == tws_pkg::TWS_SEL_NONE ? `TWS_RESP_SLVERR :
          `TWS_RESP_OKAY;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 32'h0000_0000;
      w_q <= 32'h0000_0000;
      strb0_q <= 1'b0;
    end else begin
      if (aw_hs) begin
        aw_q <= awaddr;
      end
      if (w_hs) begin
        w_q <= wdata;
        strb0_q <= wstrb[0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `TWS_RESP_OKAY;
    end else begin
      arready <= !next_rvalid;
      rvalid <= next_rvalid;
      if (ar_hs) begin
        rdata <= {24'h00_0000, rd_byte};
        rresp <= rsel == tws_pkg::TWS_SEL_NONE ? `TWS_RESP_SLVERR :
          `TWS_RESP_OKAY;
      end
    end
  end

  // Software registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      own_slave_address <= `TWS_RST_OWN_ADDR;
      serial_data_reg <= `TWS_RST_DATA;
      prescaler <= 2'b00;
      sleep_mode <= 1'b0;
      acknowledge_enable <= 1'b0;
      stop_request <= 1'b0;
      interface_enable <= 1'b0;
    end else if (wr_lane0) begin
      case (wsel)
        tws_pkg::TWS_SEL_OWN: own_slave_address <= w_q[7:0];
        tws_pkg::TWS_SEL_DATA: serial_data_reg <= w_q[7:0]; // see RULE18
        tws_pkg::TWS_SEL_STATUS: prescaler <= w_q[1:0];
        tws_pkg::TWS_SEL_SLEEP: sleep_mode <= w_q[0];
        tws_pkg::TWS_SEL_CTRL: begin
          acknowledge_enable <= w_q[`TWS_BIT_ACK_EN];
          stop_request <= w_q[`TWS_BIT_STOP];
          interface_enable <= w_q[`TWS_BIT_ENABLE];
        end
        default: begin
        end
      endcase
    end
  end

  // Hardware set beats a software clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      interrupt_flag <= 1'b0;
      serial_status_reg <= `TWS_ST_NO_INFO;
    end else if (flag_set) begin
      interrupt_flag <= 1'b1; // see RULE5
      serial_status_reg <= next_code;
    end else if (flag_clear) begin
      interrupt_flag <= 1'b0; // see RULE20
      serial_status_reg <= `TWS_ST_NO_INFO;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      start_request <= 1'b0;
    end else if (start_done) begin
      start_request <= 1'b0;
    end else if (wr_ctrl) begin
      start_request <= w_q[`TWS_BIT_START];
    end
  end

  // Pin synchronisers and bus watch
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_d <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_d <= 1'b1;
      bus_busy <= 1'b0;
    end else begin
      scl_s1 <= scl_i;
      scl_s2 <= scl_s1;
      scl_d <= scl_s2;
      sda_s1 <= sda_i;
      sda_s2 <= sda_s1;
      sda_d <= sda_s2;
      if (start_det) begin
        bus_busy <= 1'b1;
      end else if (stop_det) begin
        bus_busy <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arb_pend <= 1'b0;
      wake_up <= 1'b0;
    end else begin
      if (arb_lost) begin
        arb_pend <= 1'b1;
      end else if (addr_set || stop_det) begin
        arb_pend <= 1'b0; // see RULE6
      end
      wake_up <= addr_done && addr_match && sleep_mode; // see RULE16
    end
  end

  // Bus protocol; sleep matching uses the same sampled bus clock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= tws_pkg::TWS_IDLE;
      scl_o <= 1'b0;
      sda_o <= 1'b0;
      scl_oe_n <= 1'b1;
      sda_oe_n <= 1'b1;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      ack_seen <= 1'b0;
      hold_cnt <= 8'h00;
    end else if (!interface_enable) begin
      state <= tws_pkg::TWS_IDLE;
      scl_oe_n <= 1'b1;
      sda_oe_n <= 1'b1;
    end else if (bus_event) begin
      state <= start_det ? tws_pkg::TWS_ADDR : tws_pkg::TWS_IDLE;
      bit_cnt <= 4'h0;
      scl_oe_n <= 1'b1;
      sda_oe_n <= 1'b1;
    end else begin
      case (state)
        tws_pkg::TWS_IDLE: begin
          bit_cnt <= 4'h0;
          hold_cnt <= 8'h00;
          if (start_det) begin
            state <= tws_pkg::TWS_ADDR;
          end else if (start_request && !bus_busy) begin
            state <= tws_pkg::TWS_START_GEN; // see RULE11
          end
        end
        tws_pkg::TWS_ADDR: begin
          if (scl_rise) begin
            shreg <= {shreg[6:0], sda_s2};
            bit_cnt <= bit_cnt + 4'h1;
          end
          if (addr_done && addr_match) begin
            sda_oe_n <= 1'b0; // see RULE1
            state <= tws_pkg::TWS_ADDR_ACK; // see RULE4
          end else if (addr_done) begin
            state <= tws_pkg::TWS_IGNORE; // see RULE15
          end
        end
        tws_pkg::TWS_ADDR_ACK: begin
          if (scl_fall) begin
            sda_oe_n <= 1'b1;
            scl_oe_n <= 1'b0; // see RULE17
            state <= tws_pkg::TWS_WAIT;
          end
        end
        tws_pkg::TWS_WAIT: begin
          // Held bus clock makes the master wait for software; see RULE21
          if (flag_clear && tx_code) begin
            shreg <= {serial_data_reg[6:0], 1'b0}; // see RULE7
            sda_oe_n <= serial_data_reg[7]; // see RULE8
            scl_oe_n <= 1'b1;
            bit_cnt <= 4'h0;
            state <= tws_pkg::TWS_TX;
          end else if (flag_clear) begin
            scl_oe_n <= 1'b1;
            state <= tws_pkg::TWS_IDLE; // see RULE10
          end
        end
        tws_pkg::TWS_TX: begin
          if (scl_fall && bit_cnt == 4'd7) begin
            sda_oe_n <= 1'b1;
            state <= tws_pkg::TWS_TX_ACK;
          end else if (scl_fall) begin
            sda_oe_n <= shreg[7];
            shreg <= {shreg[6:0], 1'b0};
            bit_cnt <= bit_cnt + 4'h1;
          end
        end
        tws_pkg::TWS_TX_ACK: begin
          if (scl_rise) begin
            ack_seen <= !sda_s2;
          end
          if (scl_fall) begin
            // Ack enable seen now decides last byte; see RULE13
            scl_oe_n <= ack_code != `TWS_ST_DATA_ACK; // see RULE9
            state <= ack_code == `TWS_ST_DATA_ACK ? tws_pkg::TWS_WAIT :
              tws_pkg::TWS_IGNORE; // see RULE12
          end
        end
        tws_pkg::TWS_IGNORE: begin
          sda_oe_n <= 1'b1; // see RULE14
          if (!interrupt_flag && start_request && !bus_busy) begin
            state <= tws_pkg::TWS_START_GEN;
          end
        end
        tws_pkg::TWS_START_GEN: begin
          sda_oe_n <= 1'b0;
          hold_cnt <= hold_cnt + 8'h01;
          if (start_done) begin
            scl_oe_n <= 1'b0;
            state <= tws_pkg::TWS_WAIT;
          end
        end
        default: state <= tws_pkg::TWS_IDLE;
      endcase
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_addressed;
    state == tws_pkg::TWS_ADDR_ACK && scl_fall && interface_enable &&
      !start_det && !stop_det;
  endsequence

  a_read_match: assert property (addr_done && addr_match && //see RULE1
    interface_enable |=> state == tws_pkg::TWS_ADDR_ACK && !sda_oe_n)
    else $error("own read address not acknowledged");
  a_gc_ignored: assert property (addr_done && //see RULE2
    shreg[7:1] == 7'h00 && !own_slave_address[0] |=>
    state != tws_pkg::TWS_ADDR_ACK)
    else $error("general call answered while disabled");
  a_ack_disable: assert property (addr_done && // see RULE15
    !acknowledge_enable |=> state != tws_pkg::TWS_ADDR_ACK)
    else $error("address answered with ack enable low");
  a_status_addr: assert property (s_addressed |=> //see RULE5
    interrupt_flag && (serial_status_reg == `TWS_ST_SLA_R_ACK ||
    serial_status_reg == `TWS_ST_ARB_SLA_R) && !scl_oe_n)
    else $error("address match did not raise flag");
  a_flag_sticky: assert property (interrupt_flag && // see RULE20
    !flag_clear |=> interrupt_flag)
    else $error("flag dropped without software clear");
  a_stretch_hold: assert property (state == tws_pkg::TWS_WAIT && // see RULE21
    interrupt_flag && tx_code && interface_enable |-> !scl_oe_n)
    else $error("clock not stretched while flag set");
  a_nack_code: assert property (ack_done && !ack_seen //see RULE10
    && !bus_event |=> serial_status_reg == `TWS_ST_DATA_NACK)
    else $error("nack did not give 0xC0");
  a_last_release: assert property (state == tws_pkg::TWS_IGNORE // see RULE14
    |=> sda_oe_n)
    else $error("data line driven after last byte");
  a_wake_pulse: assert property (addr_done && addr_match && //see RULE16
    sleep_mode |=> wake_up)
    else $error("no wake-up on sleep match");
endmodule

/* File: tws_bus_master.sv */
// Bus master receiver model for the two-wire slave bench
module tws_bus_master (
  input wire logic scl,
  input wire logic sda,
  output logic m_scl,
  output logic m_sda
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    m_scl = 1'h1;
    m_sda = 1'h1;
  end
  // Data changes only in the low phase, so no false START or STOP
  task automatic pulse(input logic d, output logic s);
    int n;
    #20 m_sda = d;
    #60 m_scl = 1'h1;
    n = 0;
    // Slave may stretch; bounded so a stuck line cannot hang
    while (scl !== 1'h1 && n < 20000) begin
      #10 n++;
    end
    #40 s = sda;
    #40 m_scl = 1'h0;
  endtask
  task automatic start;
    #23 m_sda = 1'h1;
    #60 m_scl = 1'h1;
    #80 m_sda = 1'h0;
    #80 m_scl = 1'h0;
  endtask
  task automatic stop;
    #23 m_sda = 1'h0;
    #60 m_scl = 1'h1;
    #80 m_sda = 1'h1;
    #160;
  endtask
  // Byte MSB first, then ack slot; ack_n high leaves SDA released
  task automatic xfer(input logic [7:0] d, input logic ack_n,
      output logic [7:0] q, output logic ak);
    // Start off the bench clock edges so pin changes never race it
    #3;
    for (int i = 7; i >= 0; i--) begin
      pulse(d[i], q[i]);
    end
    pulse(ack_n, ak);
  endtask
endmodule

/* File: two_wire_slave_transmitter_test.sv */
// Self-checking bench for the two-wire slave transmitter
`include "tws_consts.svh"
module two_wire_slave_transmitter_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [31:0] awaddr = 32'h0000_0000;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] araddr = 32'h0000_0000;
  logic awvalid = 1'h0;
  logic wvalid = 1'h0;
  logic bready = 1'h0;
  logic arvalid = 1'h0;
  logic rready = 1'h0;
  logic arb_lost = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, wake_up;
  logic scl_o, scl_oe_n, sda_o, sda_oe_n, m_scl, m_sda;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int bad_count = 0;
  int n_compared = 0;
  int wake_cnt = 0;
  int hold_run = 0;
  int last_hold = 0;
  // Pull-ups: a line is low only while some party drives it
  wire scl_w = (scl_oe_n | scl_o) & m_scl;
  wire sda_w = (sda_oe_n | sda_o) & m_sda;
  tws_slave_tx DUT (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .arb_lost(arb_lost), .scl_i(scl_w), .scl_o(scl_o),
    .scl_oe_n(scl_oe_n), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe_n(sda_oe_n), .wake_up(wake_up));
  tws_bus_master m (.scl(scl_w), .sda(sda_w), .m_scl(m_scl),
    .m_sda(m_sda));
  initial begin
    forever #10 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    if (wake_up === 1'h1)
      wake_cnt <= wake_cnt + 1;
  end
  // Length of the last span with SDA low under a high SCL
  always @(posedge aclk) begin
    if (scl_w === 1'h1 && sda_w === 1'h0) begin
      hold_run <= hold_run + 1;
    end else begin
      if (hold_run != 0)
        last_hold <= hold_run;
      hold_run <= 0;
    end
  end
  task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [7:0] d,
      input logic [1:0] er = 2'b00);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    n = 0;
    do begin
      @(posedge aclk);
      if (awready === 1'h1)
        awvalid <= 1'h0;
      if (wready === 1'h1)
        wvalid <= 1'h0;
      n++;
    end while (bvalid !== 1'h1 && n < 1000);
    bready <= 1'h0;
    chk("bvalid", 1, 32'(bvalid));
    chk("bresp", 32'(er), 32'(bresp));
  endtask
  task automatic rd(input logic [31:0] a, input logic [1:0] er,
      output logic [31:0] d);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    n = 0;
    do begin
      @(posedge aclk);
      if (arready === 1'h1)
        arvalid <= 1'h0;
      n++;
    end while (rvalid !== 1'h1 && n < 1000);
    rready <= 1'h0;
    chk("rvalid", 1, 32'(rvalid));
    d = rdata;
    chk("rresp", 32'(er), 32'(rresp));
  endtask
  task automatic rchk(input logic [31:0] a, input logic [7:0] e,
      input string nm);
    logic [31:0] d;
    rd(a, 2'b00, d);
    chk(nm, {24'h00_0000, e}, d);
  endtask
  // Poll the flag, then status with the prescaler bits masked
  task automatic wait_st(input logic [7:0] e);
    logic [31:0] d;
    int n;
    n = 0;
    do begin
      rd(`TWS_OFS_CTRL, 2'b00, d);
      n++;
    end while (d[7] !== 1'h1 && n < 300);
    chk("flag", 32'h0000_0080, d & 32'h0000_0080);
    rd(`TWS_OFS_STATUS, 2'b00, d);
    chk("status", {24'h00_0000, e}, d & 32'h0000_00F8);
    chk("stretch", 32'(e == 8'hC0 || e == 8'hC8), 32'(scl_oe_n));
  endtask
  task automatic sess(input logic [7:0] a, input logic ak_exp);
    logic [7:0] q;
    logic ak;
    m.start();
    m.xfer(a, 1'h1, q, ak);
    chk("addr_ack", 32'(ak_exp), 32'(ak));
    if (ak !== 1'h0)
      m.stop();
  endtask
  task automatic rbyte(input logic [7:0] e, input logic ack_n);
    logic [7:0] q;
    logic ak;
    m.xfer(8'hFF, ack_n, q, ak);
    chk("tx_byte", 32'(e), 32'(q));
  endtask
  task automatic t_regs;
    logic [31:0] d;
    rchk(`TWS_OFS_OWN_ADDR, 8'h00, "own_rst");
    rchk(`TWS_OFS_CTRL, 8'h00, "ctrl_rst");
    rchk(`TWS_OFS_STATUS, 8'hF8, "status_rst");
    rchk(`TWS_OFS_DATA, 8'hFF, "data_rst");
    rd(32'h0000_0040, 2'b10, d);
    chk("unmapped", 32'h0000_0000, d);
    wr(32'h0000_0040, 8'h55, 2'b10);
    wr(`TWS_OFS_OWN_ADDR, 8'hA4);
    rchk(`TWS_OFS_OWN_ADDR, 8'hA4, "own_addr");
    wr(`TWS_OFS_STATUS, 8'h03);
    wr(`TWS_OFS_CTRL, 8'h44);
  endtask
  // Write direction, foreign address, disabled call, ack enable off
  task automatic t_ignore;
    logic [7:0] tab [4] = '{8'hA4, 8'hA7, 8'h01, 8'hA5};
    for (int i = 0; i < 4; i++) begin
      if (i == 3)
        wr(`TWS_OFS_CTRL, 8'h04);
      sess(tab[i], 1'h1);
    end
    wr(`TWS_OFS_CTRL, 8'h44);
  endtask
  task automatic t_read2;
    sess(8'hA5, 1'h0);
    wait_st(8'hA8);
    wr(`TWS_OFS_CTRL, 8'h44);
    rchk(`TWS_OFS_CTRL, 8'hC4, "flag_kept");
    wr(`TWS_OFS_DATA, 8'h3C);
    wr(`TWS_OFS_CTRL, 8'hC4);
    rbyte(8'h3C, 1'h0);
    wait_st(8'hB8);
    wr(`TWS_OFS_DATA, 8'h96);
    wr(`TWS_OFS_CTRL, 8'h84);
    rbyte(8'h96, 1'h0);
    wait_st(8'hC8);
    wr(`TWS_OFS_CTRL, 8'hC4);
    rbyte(8'hFF, 1'h0);
    m.stop();
  endtask
  task automatic t_arb;
    wr(`TWS_OFS_OWN_ADDR, 8'hA5);
    @(posedge aclk);
    arb_lost <= 1'h1;
    @(posedge aclk);
    arb_lost <= 1'h0;
    sess(8'h01, 1'h0);
    wait_st(8'hB0);
    wr(`TWS_OFS_DATA, 8'h5A);
    wr(`TWS_OFS_CTRL, 8'h84);
    rbyte(8'h5A, 1'h1);
    wait_st(8'hC0);
    wr(`TWS_OFS_CTRL, 8'hC4);
    m.stop();
  endtask
  // Sleep match, then a START request on the closing status
  task automatic t_sleep_start;
    int w;
    int n;
    wr(`TWS_OFS_SLEEP, 8'h01);
    w = wake_cnt;
    sess(8'hA5, 1'h0);
    wait_st(8'hA8);
    chk("wake", w + 1, wake_cnt);
    wr(`TWS_OFS_SLEEP, 8'h00);
    wr(`TWS_OFS_DATA, 8'h81);
    wr(`TWS_OFS_CTRL, 8'hC4);
    rbyte(8'h81, 1'h1);
    wait_st(8'hC0);
    wr(`TWS_OFS_CTRL, 8'hE4);
    m.stop();
    wait_st(8'h08);
    n = int'(last_hold >= 198 && last_hold <= 202);
    chk("start_hold", 1, n);
    wr(`TWS_OFS_CTRL, 8'h80);
  endtask
  task automatic test_done;
    if (bad_count == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    t_regs();
    t_ignore();
    t_read2();
    t_arb();
    t_sleep_start();
    test_done();
  end
  initial begin
    #1_000_000;
    bad_count++;
    test_done();
  end
endmodule
